// ---- hw/pdmap_pkg.sv ----
// constants, codes and register map of the process data word map
package pdmap_pkg;
    // selection table geometry
    localparam int SEL_W = 5;
    localparam int SADDR_W = 5;
    localparam int SEL_DEPTH = 32;
    localparam int TX_BANK_BIT = 4;
    typedef logic [SEL_W-1:0] sel_t;
    typedef logic [SADDR_W-1:0] saddr_t;

    // word positions inside one message
    localparam logic [3:0] STATUS_WORD = 4'h1;
    localparam logic [3:0] FIRST_WORD = 4'h2;
    localparam logic [3:0] LAST_WORD = 4'hc;
    localparam int TX_WORDS = 12;

    // receive selection codes
    localparam sel_t CODE_LOOP_FB = 5'h03;
    localparam sel_t CODE_TORQUE = 5'h04;
    localparam sel_t CODE_FWD_LIM = 5'h05;
    localparam sel_t CODE_REV_LIM = 5'h06;
    localparam sel_t CODE_MOT_TQ = 5'h07;
    localparam sel_t CODE_BRK_TQ = 5'h08;
    localparam sel_t CODE_VIN = 5'h09;
    localparam sel_t CODE_VOUT = 5'h0a;
    localparam sel_t CODE_VOLT = 5'h0b;
    localparam sel_t CODE_ANAOUT1 = 5'h0c;
    localparam sel_t CODE_ANAOUT2 = 5'h0d;
    localparam sel_t CODE_PREF_HI = 5'h0e;
    localparam sel_t CODE_PREF_LO = 5'h0f;
    localparam sel_t CODE_PFB_HI = 5'h10;
    localparam sel_t CODE_PFB_LO = 5'h11;
    localparam sel_t CODE_PFB_FLAG = 5'h12;
    // transmit selection: code that returns the status word, count of codes
    localparam sel_t CODE_TX_STATUS = 5'h19;
    localparam int ACT_CODES = 26;

    // setpoint limits (1000 = 100.0 %)
    localparam logic [15:0] LOOP_FB_MAX = 16'h03e8;
    localparam logic [15:0] TORQUE_LIM = 16'h0bb8;
    localparam logic [15:0] MOT_TQ_MAX = 16'h0bb8;
    localparam logic [15:0] BRK_TQ_MAX = 16'h07d0;
    localparam logic [15:0] VIN_MAX = 16'h01ff;
    localparam logic [15:0] VOUT_MAX = 16'h000f;
    localparam logic [15:0] VOLT_MAX = 16'h03e8;
    localparam logic [15:0] ANAOUT_LIM = 16'h03e8;
    localparam logic [15:0] FMAX_RESET = 16'h1388;

    // status word fields
    localparam int ST_RUN_LSB = 0;
    localparam int ST_READY_BIT = 8;
    localparam int ST_GROUP_LSB = 9;
    localparam int ST_SYNC_BIT = 11;
    localparam int ST_OVL_BIT = 12;
    localparam int ST_SRC_LSB = 13;
    localparam int ST_HB_BIT = 15;

    typedef enum logic [7:0] {
        RUN_NONE = 8'h00,
        RUN_FWD = 8'h01,
        RUN_REV = 8'h02,
        RUN_STOP = 8'h03,
        RUN_FAULT = 8'h04,
        RUN_POWER_OFF = 8'h05,
        RUN_PREEXCITE = 8'h06
    } run_state_e;

    typedef enum logic [0:0] {
        TX_IDLE = 1'b0,
        TX_WALK = 1'b1
    } tx_state_e;

    // apb register map
    localparam int ADDR_W = 12;
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_FMAX = 12'h004;
    localparam logic [11:0] REG_IRQ_STAT = 12'h008;
    localparam logic [11:0] REG_IRQ_MASK = 12'h00c;
    localparam logic [11:0] REG_STATUS = 12'h010;
    localparam logic [11:0] REG_POS_FB = 12'h014;
    localparam logic [11:0] RX_SEL_BASE = 12'h040;
    localparam logic [11:0] TX_SEL_BASE = 12'h080;
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RESET = 1'b1;

    // interrupt status bits
    localparam int IRQ_W = 4;
    localparam int IRQ_FRAME = 0;
    localparam int IRQ_CLAMP = 1;
    localparam int IRQ_POS_FB = 2;
    localparam int IRQ_BAD_CODE = 3;
endpackage

// ---- hw/sel_mem_if.sv ----
// write port and three read ports of the selection table
interface sel_mem_if;
    import pdmap_pkg::*;
    logic we;
    pdmap_pkg::saddr_t waddr;
    pdmap_pkg::sel_t wdata;
    pdmap_pkg::saddr_t rx_addr;
    pdmap_pkg::saddr_t tx_addr;
    pdmap_pkg::saddr_t bus_addr;
    pdmap_pkg::sel_t rx_code;
    pdmap_pkg::sel_t tx_code;
    pdmap_pkg::sel_t bus_code;
    modport owner (output we, waddr, wdata, rx_addr, tx_addr, bus_addr, input rx_code, tx_code, bus_code);
    modport mem (input we, waddr, wdata, rx_addr, tx_addr, bus_addr, output rx_code, tx_code, bus_code);
endinterface

// ---- hw/sel_table.sv ----
// selection code table with registered read ports
module sel_table #(
    parameter int DEPTH = pdmap_pkg::SEL_DEPTH // number of entries
) (
    input wire logic clk, // system clock
    input wire logic sys_rst, // synchronous reset
    sel_mem_if.mem port // table access
);
    import pdmap_pkg::*;

    sel_t cells [DEPTH];

    // every address bit pattern must land on an entry
    if (DEPTH < 2**SADDR_W) begin : g_depth_check
        $error("sel_table depth too small");
    end

    // cleared to zero so every word starts as invalid
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                cells[i] <= '0;
            end
        end else if (port.we) begin
            cells[port.waddr] <= port.wdata;
        end
    end

    // read data always out of a register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            port.rx_code <= '0;
            port.tx_code <= '0;
            port.bus_code <= '0;
        end else begin
            port.rx_code <= cells[port.rx_addr];
            port.tx_code <= cells[port.tx_addr];
            port.bus_code <= cells[port.bus_addr];
        end
    end
endmodule

// ---- hw/fieldbus_process_data_map.sv ----
// receive word decoder and response composer for fieldbus process data
// Function
// - receive words 2 to 12 carry references, each meaning set by its own code
// - code 3 is process loop feedback, 0 to 1000
// - code 4 is signed torque setpoint, -3000 to 3000
// - codes 5 and 6 are forward and reverse frequency limits, 0 to fmax
// - code 7 motoring torque limit 0..3000, code 8 braking 0..2000
// - code 9 virtual inputs up to 0x1ff, code 10 virtual outputs up to 0x0f
// - code 11 is separated v/f voltage setpoint, 0 to 1000
// - codes 12 and 13 are signed analog output setpoints, -1000 to 1000
// - codes 14 to 17 carry position reference and feedback halves
// - new position feedback taken only after flag code 18 goes one then zero
// - status word is the first word of every response
// - status bits 0-7 hold the run state
// - status bit 8 shows bus ready to run
// - bits 9-10 motor group, bit 11 motor type, bit 12 overload alarm
// - bits 13-14 command source, bit 15 heartbeat feedback
// - response words 2 to 12 carry actual values chosen by their codes
//
// The implementer's own choices: the APB slave port and the register addresses.
module fieldbus_process_data_map (
    input wire logic clk, // 40 MHz system clock
    input wire logic sys_rst, // synchronous reset, high
    input wire logic [pdmap_pkg::ADDR_W-1:0] paddr, // apb address
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped access
    output logic irq, // level interrupt
    input wire logic rx_valid, // receive word strobe
    input wire logic [3:0] rx_idx, // receive word position
    input wire logic [15:0] rx_data, // receive word value
    input wire logic tx_req, // start a response
    output logic tx_valid, // response word strobe
    output logic [3:0] tx_idx, // response word position
    output logic [15:0] tx_data, // response word value
    input wire pdmap_pkg::run_state_e run_state, // drive run state
    input wire logic bus_ready, // dc bus established
    input wire logic [1:0] motor_group, // active motor group
    input wire logic motor_sync, // synchronous motor
    input wire logic overload_alarm, // overload pre-alarm
    input wire logic [1:0] cmd_source, // run command source
    input wire logic heartbeat, // heartbeat present
    input wire logic [16*pdmap_pkg::ACT_CODES-1:0] act_value, // actual values by code
    output logic [15:0] process_loop_feedback, // process loop feedback
    output logic [15:0] torque_ref, // signed torque setpoint
    output logic [15:0] fwd_freq_limit, // forward upper frequency
    output logic [15:0] rev_freq_limit, // reverse upper frequency
    output logic [15:0] motoring_torque_limit, // motoring torque limit
    output logic [15:0] braking_torque_limit, // braking torque limit
    output logic [8:0] virt_in, // virtual input terminals
    output logic [3:0] virt_out, // virtual output terminals
    output logic [15:0] vf_voltage, // separated v/f voltage
    output logic [15:0] analog_output_setpoint1, // analog output 1
    output logic [15:0] analog_output_setpoint2, // analog output 2
    output logic [31:0] pos_ref, // position reference
    output logic [31:0] pos_fb // committed position feedback
);
    import pdmap_pkg::*;

    sel_mem_if smem ();
    sel_table #(.DEPTH(SEL_DEPTH)) u_sel (.clk(clk), .sys_rst(sys_rst), .port(smem.mem));

    logic ctrl_en;
    logic [15:0] fmax;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] events;
    logic [15:0] drive_status_word;
    logic [15:0] next_status;
    logic rx_v1;
    logic [3:0] rx_idx1;
    logic [15:0] rx_data1;
    logic [15:0] next_val;
    logic clamp_hit;
    logic bad_code;
    logic pos_flag;
    logic [31:0] pfb_stage;
    logic pfb_commit;
    tx_state_e tx_state;
    logic [3:0] tx_ptr;
    logic tx_v1;
    logic [3:0] tx_idx1;
    logic [15:0] act_word;
    logic wr_fire;
    logic rd_take;

    // unsigned clamp, returns {hit, value}
    function automatic logic [16:0] clamp_u(input logic [15:0] v, input logic [15:0] hi);
        clamp_u = (v > hi) ? {1'b1, hi} : {1'b0, v};
    endfunction

    // symmetric signed clamp, returns {hit, value}
    function automatic logic [16:0] clamp_s(input logic [15:0] v, input logic [15:0] lim);
        logic signed [15:0] sv;
        logic signed [15:0] sl;
        sv = v;
        sl = lim;
        if (sv > sl) clamp_s = {1'b1, lim};
        else if (sv < -sl) clamp_s = {1'b1, 16'(-sl)};
        else clamp_s = {1'b0, v};
    endfunction

    // selection register hit: right bank, aligned, word index 2..12
    function automatic logic sel_ok(input logic [11:0] a, input logic [11:0] base);
        sel_ok = (a[11:6] == base[11:6]) && (a[1:0] == 2'b00) && (a[5:2] >= FIRST_WORD) && (a[5:2] <= LAST_WORD);
    endfunction

    function automatic logic mapped(input logic [11:0] a, input logic wr);
        case (a)
            REG_CTRL, REG_FMAX, REG_IRQ_STAT, REG_IRQ_MASK: mapped = 1'b1;
            REG_STATUS, REG_POS_FB: mapped = !wr;
            default: mapped = sel_ok(a, RX_SEL_BASE) || sel_ok(a, TX_SEL_BASE);
        endcase
    endfunction

    // table ports: receive bank low, transmit bank high
    assign smem.rx_addr = {1'b0, rx_idx};
    assign smem.tx_addr = {1'b1, tx_ptr};
    assign smem.bus_addr = {paddr[7], paddr[5:2]};
    assign smem.we = wr_fire && (sel_ok(paddr, RX_SEL_BASE) || sel_ok(paddr, TX_SEL_BASE));
    assign smem.waddr = {paddr[7], paddr[5:2]};
    assign smem.wdata = pwdata[SEL_W-1:0];

    // one wait state on every transfer so table reads come out of a register
    assign rd_take = psel && penable && !pready;
    assign wr_fire = psel && penable && pready && pwrite;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= rd_take;
            pslverr <= rd_take && !mapped(paddr, pwrite);
            if (rd_take && !pwrite) begin
                case (paddr)
                    REG_CTRL: prdata <= 32'(ctrl_en);
                    REG_FMAX: prdata <= 32'(fmax);
                    REG_IRQ_STAT: prdata <= 32'(irq_status);
                    REG_IRQ_MASK: prdata <= 32'(irq_mask);
                    REG_STATUS: prdata <= 32'(drive_status_word);
                    REG_POS_FB: prdata <= pos_fb;
                    default: prdata <= mapped(paddr, 1'b0) ? 32'(smem.bus_code) : 32'h0;
                endcase
            end else begin
                prdata <= '0;
            end
        end
    end

    // software control registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_en <= CTRL_EN_RESET;
            fmax <= FMAX_RESET;
            irq_mask <= '0;
        end else if (wr_fire) begin
            if (paddr == REG_CTRL) ctrl_en <= pwdata[CTRL_EN_BIT];
            if (paddr == REG_FMAX) fmax <= pwdata[15:0];
            if (paddr == REG_IRQ_MASK) irq_mask <= pwdata[IRQ_W-1:0];
        end
    end

    // sticky events, write one to clear; a new event beats the clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_status <= '0;
            irq <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~((wr_fire && paddr == REG_IRQ_STAT) ? pwdata[IRQ_W-1:0] : '0)) | events;
            irq <= |(irq_status & irq_mask);
        end
    end

    // only words 2..12 are references; control word and others pass by
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_v1 <= 1'b0;
            rx_idx1 <= '0;
            rx_data1 <= '0;
        end else begin
            rx_v1 <= rx_valid && ctrl_en && rx_idx >= FIRST_WORD && rx_idx <= LAST_WORD;
            rx_idx1 <= rx_idx;
            rx_data1 <= rx_data;
        end
    end

    // value and clamp result for the code read from the table
    always_comb begin
        next_val = rx_data1;
        clamp_hit = 1'b0;
        bad_code = 1'b0;
        case (smem.rx_code)
            CODE_LOOP_FB: {clamp_hit, next_val} = clamp_u(rx_data1, LOOP_FB_MAX);
            CODE_TORQUE: {clamp_hit, next_val} = clamp_s(rx_data1, TORQUE_LIM);
            CODE_FWD_LIM, CODE_REV_LIM: {clamp_hit, next_val} = clamp_u(rx_data1, fmax);
            CODE_MOT_TQ: {clamp_hit, next_val} = clamp_u(rx_data1, MOT_TQ_MAX);
            CODE_BRK_TQ: {clamp_hit, next_val} = clamp_u(rx_data1, BRK_TQ_MAX);
            CODE_VIN: {clamp_hit, next_val} = clamp_u(rx_data1, VIN_MAX);
            CODE_VOUT: {clamp_hit, next_val} = clamp_u(rx_data1, VOUT_MAX);
            CODE_VOLT: {clamp_hit, next_val} = clamp_u(rx_data1, VOLT_MAX);
            CODE_ANAOUT1, CODE_ANAOUT2: {clamp_hit, next_val} = clamp_s(rx_data1, ANAOUT_LIM);
            CODE_PREF_HI, CODE_PREF_LO, CODE_PFB_HI, CODE_PFB_LO, CODE_PFB_FLAG: next_val = rx_data1;
            default: bad_code = 1'b1;
        endcase
    end

    assign events[IRQ_FRAME] = rx_v1 && rx_idx1 == LAST_WORD;
    assign events[IRQ_CLAMP] = rx_v1 && clamp_hit;
    assign events[IRQ_POS_FB] = pfb_commit;
    assign events[IRQ_BAD_CODE] = rx_v1 && bad_code;

    // setpoints; unlisted codes fall to default and hold every value
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            process_loop_feedback <= '0;
            torque_ref <= '0;
            fwd_freq_limit <= '0;
            rev_freq_limit <= '0;
            motoring_torque_limit <= '0;
            braking_torque_limit <= '0;
            virt_in <= '0;
            virt_out <= '0;
            vf_voltage <= '0;
            analog_output_setpoint1 <= '0;
            analog_output_setpoint2 <= '0;
        end else if (rx_v1) begin
            case (smem.rx_code)
                CODE_LOOP_FB: process_loop_feedback <= next_val;
                CODE_TORQUE: torque_ref <= next_val;
                CODE_FWD_LIM: fwd_freq_limit <= next_val;
                CODE_REV_LIM: rev_freq_limit <= next_val;
                CODE_MOT_TQ: motoring_torque_limit <= next_val;
                CODE_BRK_TQ: braking_torque_limit <= next_val;
                CODE_VIN: virt_in <= next_val[8:0];
                CODE_VOUT: virt_out <= next_val[3:0];
                CODE_VOLT: vf_voltage <= next_val;
                CODE_ANAOUT1: analog_output_setpoint1 <= next_val;
                CODE_ANAOUT2: analog_output_setpoint2 <= next_val;
                default: ;
            endcase
        end
    end

    // feedback halves wait in a stage until the flag falls
    assign pfb_commit = rx_v1 && smem.rx_code == CODE_PFB_FLAG && pos_flag && rx_data1 == 16'h0000;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pos_ref <= '0;
            pfb_stage <= '0;
            pos_fb <= '0;
            pos_flag <= 1'b0;
        end else begin
            if (rx_v1 && smem.rx_code == CODE_PREF_HI) pos_ref[31:16] <= rx_data1;
            if (rx_v1 && smem.rx_code == CODE_PREF_LO) pos_ref[15:0] <= rx_data1;
            if (rx_v1 && smem.rx_code == CODE_PFB_HI) pfb_stage[31:16] <= rx_data1;
            if (rx_v1 && smem.rx_code == CODE_PFB_LO) pfb_stage[15:0] <= rx_data1;
            if (rx_v1 && smem.rx_code == CODE_PFB_FLAG) pos_flag <= rx_data1 != 16'h0000;
            if (pfb_commit) pos_fb <= pfb_stage;
        end
    end

    // status word fields from the drive core
    always_comb begin
        next_status = '0;
        next_status[ST_RUN_LSB +: 8] = run_state;
        next_status[ST_READY_BIT] = bus_ready;
        next_status[ST_GROUP_LSB +: 2] = motor_group;
        next_status[ST_SYNC_BIT] = motor_sync;
        next_status[ST_OVL_BIT] = overload_alarm;
        next_status[ST_SRC_LSB +: 2] = cmd_source;
        next_status[ST_HB_BIT] = heartbeat;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) drive_status_word <= '0;
        else drive_status_word <= next_status;
    end

    // response walk; a request during a walk is ignored
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_state <= TX_IDLE;
            tx_ptr <= STATUS_WORD;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    tx_ptr <= STATUS_WORD;
                    if (tx_req) tx_state <= TX_WALK;
                end
                TX_WALK: begin
                    tx_ptr <= tx_ptr + 4'h1;
                    if (tx_ptr == LAST_WORD) tx_state <= TX_IDLE;
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    // actual value chosen by the transmit code; unknown codes send zero
    always_comb begin
        act_word = '0;
        if (smem.tx_code == CODE_TX_STATUS) act_word = drive_status_word;
        else if (int'(smem.tx_code) < ACT_CODES && smem.tx_code != '0) act_word = act_value[16*smem.tx_code +: 16];
    end

    // second stage waits for the registered table read
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_v1 <= 1'b0;
            tx_idx1 <= '0;
            tx_valid <= 1'b0;
            tx_idx <= '0;
            tx_data <= '0;
        end else begin
            tx_v1 <= tx_state == TX_WALK;
            tx_idx1 <= tx_ptr;
            tx_valid <= tx_v1;
            tx_idx <= tx_idx1;
            tx_data <= (tx_idx1 == STATUS_WORD) ? drive_status_word : act_word;
        end
    end

    loop_clamp_a: assert property (@(posedge clk) disable iff (sys_rst)
        rx_v1 && smem.rx_code == CODE_LOOP_FB |=> process_loop_feedback
            == (($past(rx_data1) > LOOP_FB_MAX) ? LOOP_FB_MAX : $past(rx_data1)))
        else $error("process loop feedback not clamped");
    torque_range_a: assert property (@(posedge clk) disable iff (sys_rst)
        $signed(torque_ref) <= $signed(TORQUE_LIM) && $signed(torque_ref) >= -$signed(TORQUE_LIM))
        else $error("torque setpoint out of range");
    brake_limit_a: assert property (@(posedge clk) disable iff (sys_rst)
        $changed(braking_torque_limit) |-> braking_torque_limit <= BRK_TQ_MAX && $past(smem.rx_code) == CODE_BRK_TQ)
        else $error("braking limit wrong");
    ignored_code_a: assert property (@(posedge clk) disable iff (sys_rst)
        rx_v1 && bad_code |=> $stable(process_loop_feedback) && $stable(torque_ref)
            && $stable(vf_voltage) && $stable(pos_fb))
        else $error("ignored word changed a setpoint");
    pos_commit_a: assert property (@(posedge clk) disable iff (sys_rst)
        $changed(pos_fb) |-> $past(rx_v1 && smem.rx_code == CODE_PFB_FLAG && pos_flag && rx_data1 == 16'h0000))
        else $error("position feedback taken without flag sequence");
    status_first_a: assert property (@(posedge clk) disable iff (sys_rst)
        tx_req && tx_state == TX_IDLE |-> ##3 tx_valid && tx_idx == STATUS_WORD && tx_data == $past(drive_status_word))
        else $error("status word not first");
    walk_length_a: assert property (@(posedge clk) disable iff (sys_rst)
        tx_req && tx_state == TX_IDLE |-> ##3 tx_valid[*8] ##1 tx_valid[*3] ##1 tx_valid && tx_idx == LAST_WORD
            ##1 !tx_valid)
        else $error("response walk length wrong");
    status_bits_a: assert property (@(posedge clk) disable iff (sys_rst)
        ##1 drive_status_word[ST_READY_BIT] == $past(bus_ready) && drive_status_word[7:0] == $past(run_state))
        else $error("status word does not follow drive");
    irq_level_a: assert property (@(posedge clk) disable iff (sys_rst)
        ##1 irq == $past(|(irq_status & irq_mask)))
        else $error("interrupt level wrong");
endmodule

// ---- tb/fb_master.sv ----
// behavioural fieldbus master driving receive words and response requests
module fb_master (
    input wire logic clk, // system clock
    output logic rx_valid, // word strobe
    output logic [3:0] rx_idx, // word position
    output logic [15:0] rx_data, // word value
    output logic tx_req // response request
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {rx_valid, rx_idx, rx_data, tx_req} = '0;
    end
    // one word per call; data inverted once released so a stale value never matches
    task send(input logic [3:0] i, input logic [15:0] d);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_idx <= i;
        rx_data <= d;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_data <= ~d;
    endtask
    // one-cycle response request
    task req();
        @(posedge clk);
        tx_req <= 1'b1;
        @(posedge clk);
        tx_req <= 1'b0;
    endtask
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the process data word map
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pdmap_pkg::*;
`define CHK(a, b) begin logic [63:0] g, e; g = 64'(a); e = 64'(b); total_checks++; if (g !== e) begin \
bad_count++; $display("BAD %0t got %h exp %h", $time, g, e); end end
    logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, tx_req, rx_valid;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, pos_ref, pos_fb;
    logic pready, pslverr, irq, tx_valid, motor_sync = 0, overload_alarm = 0, heartbeat = 0, bus_ready = 0;
    logic [3:0] tx_idx, rx_idx, virt_out;
    logic [15:0] tx_data, rx_data, process_loop_feedback, torque_ref, fwd_freq_limit, rev_freq_limit, exp_status;
    logic [15:0] motoring_torque_limit, braking_torque_limit, vf_voltage;
    logic [15:0] analog_output_setpoint1, analog_output_setpoint2;
    logic [8:0] virt_in;
    logic [1:0] motor_group = 0, cmd_source = 0;
    run_state_e run_state = RUN_NONE;
    logic [16*ACT_CODES-1:0] act_value = '0;
    logic [15:0] va [11] = '{16'h05dc, 16'hf254, 0, 16'hffff, 16'h09c4, 16'h09c4, 16'h03ff, 16'h001f,
        16'h03e7, 16'hfb50, 16'h01f4};
    logic [19:0] tq [$];
    logic [32:0] aq [$];
    int bad_count = 0, total_checks = 0;
    always #12.5 clk = ~clk;
    fieldbus_process_data_map uut (.clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .irq, .rx_valid, .rx_idx, .rx_data, .tx_req, .tx_valid, .tx_idx, .tx_data, .run_state, .bus_ready,
        .motor_group, .motor_sync, .overload_alarm, .cmd_source, .heartbeat, .act_value,
        .process_loop_feedback, .torque_ref,
        .fwd_freq_limit, .rev_freq_limit, .motoring_torque_limit, .braking_torque_limit, .virt_in, .virt_out,
        .vf_voltage, .analog_output_setpoint1, .analog_output_setpoint2, .pos_ref, .pos_fb);
    fb_master fm (.clk, .rx_valid, .rx_idx, .rx_data, .tx_req);
    // apb master; waits for pready without assuming a latency
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        {paddr, pwrite, pwdata, psel, penable} <= {a, w, d, 2'b10};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
    endtask
    task print_verdict();
        $display("checks %0d bad %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // watcher: oldest note against each response word and read answer
    always @(posedge clk) begin
        if (tx_valid === 1'b1) `CHK({tx_idx, tx_data}, tq.pop_front())
        if (psel && penable && pready === 1'b1 && !pwrite) `CHK({pslverr, prdata}, aq.pop_front())
    end
    // hang guard, far beyond the few hundred cycles needed
    initial begin
        #100us;
        bad_count++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'hb9169750));
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        aq.push_back({1'b0, 32'h1388});
        apb(REG_FMAX, 0, 0);
        aq.push_back({1'b1, 32'h0});
        apb(12'hffc, 0, 0);
        for (int n = 2; n <= 12; n++) apb(12'(RX_SEL_BASE + 4 * n), 1, n + 1);
        va[2] = 16'($urandom_range(0, 4999));
        for (int n = 2; n <= 12; n++) fm.send(4'(n), va[n-2]);
        repeat (4) @(posedge clk);
        `CHK(process_loop_feedback, 16'h03e8)
        `CHK(torque_ref, 16'hf448)
        `CHK({fwd_freq_limit, rev_freq_limit}, {va[2], 16'h1388})
        `CHK({motoring_torque_limit, braking_torque_limit}, 32'h09c407d0)
        `CHK({virt_in, virt_out}, 13'h1fff)
        `CHK(vf_voltage, 16'h03e7)
        `CHK({analog_output_setpoint1, analog_output_setpoint2}, 32'hfc1801f4)
        aq.push_back({1'b0, 32'h3});
        apb(REG_IRQ_STAT, 0, 0);
        apb(REG_IRQ_MASK, 1, 32'h2);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b1)
        apb(REG_IRQ_STAT, 1, 32'h2);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        // receive disabled: a word must leave its setpoint alone
        apb(REG_CTRL, 1, 0);
        fm.send(2, 16'h0001);
        repeat (4) @(posedge clk);
        `CHK(process_loop_feedback, 16'h03e8)
        apb(REG_CTRL, 1, 1);
        // position halves, flag sequence and an ignored word
        for (int n = 2; n <= 7; n++) apb(12'(RX_SEL_BASE + 4 * n), 1, n < 7 ? n + 12 : 0);
        fm.send(2, 16'h8001);
        fm.send(3, 16'h1234);
        fm.send(4, 16'hc000);
        fm.send(5, 16'h5678);
        fm.send(7, 16'h0777);
        fm.send(6, 16'h0001);
        repeat (4) @(posedge clk);
        `CHK(pos_fb, 32'h0)
        fm.send(6, 16'h0000);
        repeat (4) @(posedge clk);
        `CHK({pos_ref, pos_fb}, 64'h80011234c0005678)
        `CHK({process_loop_feedback, braking_torque_limit}, 32'h03e807d0)
        aq.push_back({1'b0, 32'hd});
        apb(REG_IRQ_STAT, 0, 0);
        // response walk with random core values; a second request mid-walk is dropped
        for (int n = 2; n <= 12; n++) apb(12'(TX_SEL_BASE + 4 * n), 1, n < 12 ? n - 1 : CODE_TX_STATUS);
        for (int k = 0; k < ACT_CODES; k++) act_value[16*k+:16] <= 16'($urandom);
        {heartbeat, cmd_source, overload_alarm, motor_sync, motor_group, bus_ready} <= 8'($urandom);
        run_state <= run_state_e'($urandom_range(1, 6));
        @(posedge clk);
        exp_status = {heartbeat, cmd_source, overload_alarm, motor_sync, motor_group, bus_ready, 8'(run_state)};
        tq.push_back({4'h1, exp_status});
        for (int n = 2; n <= 11; n++) tq.push_back({4'(n), act_value[16*(n-1)+:16]});
        tq.push_back({4'hc, exp_status});
        fm.req();
        fm.req();
        repeat (24) @(posedge clk);
        `CHK(tq.size(), 0)
        print_verdict();
    end
endmodule
